// ==== design/metering_framer_pkg.sv ====
// Package: block codes, fixed block contents, carriers and state layout of the metering message framer
package metering_framer_pkg;

  // ----------------------------------------------------------------
  // Request codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_LEAD = 8'hA5;
  localparam logic [7:0] CODE_DEF = 8'hC0;
  localparam logic [7:0] CODE_CFG = 8'hC1;
  localparam logic [7:0] CODE_DATA = 8'hD1;

  // ----------------------------------------------------------------
  // Definition block, every byte ahead of the checksum
  // ----------------------------------------------------------------
  localparam logic [8*51-1:0] DEF_ROM = {
    48'hA5C0_3404_0303,                          // Code, length 34, counts 04 03 03
    96'hA5C1_A5D1_A5C2_A5D2_A5C3_A5D3,           // Six command codes
    64'h0004_A5C1_0000_0000,                     // Status flag entry, normal set
    64'h0004_A5C2_0000_0000,                     // Status flag entry, demand set
    64'h0004_A5C3_0000_0000,                     // Status flag entry, peak demand set
    64'h0100_0101_0005_0006,                     // Protocol descriptors
    8'h00                                        // Reserved
  };
  localparam logic [7:0] DEF_LAST = 8'h33;       // Index of the checksum byte

  // ----------------------------------------------------------------
  // Configuration block pieces
  // ----------------------------------------------------------------
  localparam logic [8*16-1:0] CFG_HEAD = 128'hA5C1_8401_0000_0A02_3C01_0004_0054_005C;
  localparam logic [7:0] CFG_BANKS_IDX = 8'h08;  // Digital bank count position
  localparam logic [7:0] CFG_BANKS_STD = 8'h3C;
  localparam logic [7:0] CFG_BANKS_EXT = 8'h3D;
  localparam logic [7:0] CFG_CHAN_OFS = 8'h10;   // First channel descriptor
  localparam logic [7:0] CFG_CHAN_LEN = 8'h0A;   // Bytes per descriptor
  localparam logic [7:0] CFG_NAME_LEN = 8'h06;   // Name bytes per descriptor
  localparam logic [8*60-1:0] CHAN_NAMES = {
    48'h4941_0000_0000, 48'h4942_0000_0000, 48'h4943_0000_0000, 48'h494E_0000_0000,
    48'h5641_0000_0000, 48'h5642_0000_0000, 48'h5643_0000_0000, 48'h5653_0000_0000,
    48'h4652_4551_0000, 48'h5642_4154_0000
  };
  localparam logic [8*4-1:0] CHAN_TAIL = 32'h01FF_0000; // Type, scale type, scale offset
  localparam logic [7:0] CFG_CALC_OFS = 8'h74;   // Calculation block start
  localparam logic [8*15-1:0] CFG_CALC = 120'h0000_FFFF_FFFF_FFFF_0001_0204_0506_00;
  localparam logic [7:0] CFG_LAST = 8'h83;

  // ----------------------------------------------------------------
  // Data block layout
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_LEN_STD = 8'h9A;
  localparam logic [7:0] DATA_LEN_EXT = 8'h9C;
  localparam logic [7:0] DATA_STATUS_OFS = 8'h03;
  localparam logic [7:0] DATA_ANALOG_OFS = 8'h04;
  localparam logic [7:0] DATA_STAMP_OFS = 8'h54;
  localparam logic [7:0] DATA_BANK_OFS = 8'h5C;
  localparam int ANALOG_BYTES = 80;
  localparam int STAMP_BYTES = 8;
  localparam int BANK_BYTES = 61;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  // Meter snapshot; first byte sent sits in the top bits of each field
  typedef struct packed {
    logic [7:0] status;
    logic [8*ANALOG_BYTES-1:0] analog;
    logic [8*STAMP_BYTES-1:0] stamp;
    logic [8*BANK_BYTES-1:0] banks;
  } meter_snap_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_SEND = 3'b100
  } fsm_t;

  typedef enum logic [2:0] {
    BLK_DEF = 3'b001,
    BLK_CFG = 3'b010,
    BLK_DATA = 3'b100
  } blk_t;

  typedef struct packed {
    fsm_t fsm;
    blk_t blk;
    logic [7:0] idx;
    logic [7:0] sum;
    logic ext;
    logic ext_s1;
    logic ext_s2;
    byte_beat_t tx;
    byte_beat_t hold;
    logic ascii_ready;
    meter_snap_t snap;
  } state_t;

  localparam state_t STATE_RST = '{fsm: ST_IDLE, blk: BLK_DEF, default: '0};

endpackage : metering_framer_pkg

// ==== design/metering_message_framer.sv ====
// Binary request decoder and block framer with ASCII pre-emption on a shared byte stream
//
// Functional notes
// - Request A5C0 sends definition block: A5C0, length 34.
// - Definition block counts follow: 04, 03, 03.
// - Then six command codes A5C1 A5D1 A5C2 A5D2 A5C3 A5D3.
// - Then three entries: 0004 and zero-padded configuration code each.
// - Then protocol descriptors 0100, 0101, 0005, 0006.
// - Definition block ends with reserved 00 and checksum.
// - Request A5C1 sends configuration: A5C1, 84, 01, 00, 00.
// - Geometry 0A, 02, 3C, 01; offsets 0004, 0054, 005C.
// - Extended variant declares 3D digital banks.
// - Channel descriptor: six-byte padded name, 01, FF, 0000.
// - Ten descriptors in fixed order, battery voltage last.
// - Calculation block: 00, 00, then FFFF three times.
// - Channel indices 00 01 02 04 05 06, reserved 00, checksum.
// - Request A5D1 sends data block: A5D1, 9A, status byte.
// - Then 80 bytes of analog X and Y components.
// - Then 8-byte stamp, 60 bank bytes, reserved, checksum.
// - Extended variant: length 9C, 61 banks, two reserved bytes.
// - Binary request pre-empts ASCII output, which resumes afterwards.
`timescale 1ns/1ps
`default_nettype none

module metering_message_framer
  import metering_framer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic ascii_valid,
  input wire logic [7:0] ascii_data,
  output logic ascii_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire meter_snap_t meter_snap,
  input wire logic ext_variant,
  output logic binary_busy
);

  // ----------------------------------------------------------------
  // Block content
  // ----------------------------------------------------------------

  // Configuration block byte by index
  function automatic logic [7:0] cfg_byte(input logic [7:0] i, input logic ext);
    logic [7:0] j;
    logic [7:0] ch;
    logic [7:0] off;
    logic [7:0] k;
    cfg_byte = 8'h00;
    j = i - CFG_CHAN_OFS;
    ch = j / CFG_CHAN_LEN;
    off = j % CFG_CHAN_LEN;
    k = i - CFG_CALC_OFS;
    if (i == CFG_BANKS_IDX) begin
      cfg_byte = ext ? CFG_BANKS_EXT : CFG_BANKS_STD;
    end else if (i < CFG_CHAN_OFS) begin
      cfg_byte = CFG_HEAD[8*(15-int'(i)) +: 8];
    end else if (i < CFG_CALC_OFS) begin
      if (off < CFG_NAME_LEN) begin
        cfg_byte = CHAN_NAMES[8*(59-int'(ch)*6-int'(off)) +: 8];
      end else begin
        cfg_byte = CHAN_TAIL[8*(9-int'(off)) +: 8];
      end
    end else if (i < CFG_LAST) begin
      cfg_byte = CFG_CALC[8*(14-int'(k)) +: 8];
    end
  endfunction

  // Data block byte by index, taken from the latched snapshot
  function automatic logic [7:0] data_byte(input logic [7:0] i, input logic ext, input meter_snap_t sn);
    logic [7:0] nbank;
    int k;
    data_byte = 8'h00; // Reserved bytes read zero
    nbank = ext ? CFG_BANKS_EXT : CFG_BANKS_STD;
    k = 0;
    if (i == 8'h00) begin
      data_byte = CODE_LEAD;
    end else if (i == 8'h01) begin
      data_byte = CODE_DATA;
    end else if (i == 8'h02) begin
      data_byte = ext ? DATA_LEN_EXT : DATA_LEN_STD;
    end else if (i == DATA_STATUS_OFS) begin
      data_byte = sn.status;
    end else if (i < DATA_STAMP_OFS) begin
      k = int'(i) - int'(DATA_ANALOG_OFS);
      data_byte = sn.analog[8*(ANALOG_BYTES-1-k) +: 8];
    end else if (i < DATA_BANK_OFS) begin
      k = int'(i) - int'(DATA_STAMP_OFS);
      data_byte = sn.stamp[8*(STAMP_BYTES-1-k) +: 8];
    end else if (i < DATA_BANK_OFS + nbank) begin
      k = int'(i) - int'(DATA_BANK_OFS);
      data_byte = sn.banks[8*(BANK_BYTES-1-k) +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t s_q;
  state_t s_d;
  logic [7:0] last_idx;
  logic [7:0] blk_byte;

  // Index of the checksum byte and the content byte for the open block
  always_comb begin
    last_idx = DEF_LAST;
    blk_byte = 8'h00;
    unique case (s_q.blk)
      BLK_DEF: begin
        last_idx = DEF_LAST;
        blk_byte = DEF_ROM[8*(50-int'(s_q.idx)) +: 8];
      end
      BLK_CFG: begin
        last_idx = CFG_LAST;
        blk_byte = cfg_byte(s_q.idx, s_q.ext);
      end
      BLK_DATA: begin
        last_idx = (s_q.ext ? DATA_LEN_EXT : DATA_LEN_STD) - 8'h01;
        blk_byte = data_byte(s_q.idx, s_q.ext, s_q.snap);
      end
      default: begin
        last_idx = DEF_LAST;
        blk_byte = 8'h00;
      end
    endcase
    if (s_q.idx == last_idx) begin
      blk_byte = s_q.sum;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Variant strap through two flops
    s_d.ext_s1 = ext_variant;
    s_d.ext_s2 = s_q.ext_s1;
    // Output slot drains on the handshake
    if (s_q.tx.valid && tx_ready) begin
      s_d.tx.valid = 1'b0;
    end
    // Request decode and block transmission
    unique case (s_q.fsm)
      ST_IDLE: begin
        if (rx_valid && rx_data == CODE_LEAD) begin
          s_d.fsm = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (rx_valid) begin
          if (rx_data == CODE_DEF || rx_data == CODE_CFG || rx_data == CODE_DATA) begin
            s_d.fsm = ST_SEND;
            s_d.idx = 8'h00;
            s_d.sum = 8'h00;
            s_d.ext = s_q.ext_s2;
            s_d.snap = meter_snap;
            if (rx_data == CODE_DEF) begin
              s_d.blk = BLK_DEF;
            end else if (rx_data == CODE_CFG) begin
              s_d.blk = BLK_CFG;
            end else begin
              s_d.blk = BLK_DATA;
            end
          end else if (rx_data != CODE_LEAD) begin
            s_d.fsm = ST_IDLE; // Unsupported codes are dropped
          end
        end
      end
      ST_SEND: begin
        if (!s_d.tx.valid) begin
          s_d.tx.valid = 1'b1;
          s_d.tx.data = blk_byte;
          s_d.sum = s_q.sum + blk_byte;
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.idx == last_idx) begin
            s_d.fsm = ST_IDLE;
          end
        end
      end
      default: begin
        s_d.fsm = ST_IDLE;
      end
    endcase
    // Held ASCII byte goes out only while no block is open
    if (s_q.fsm != ST_SEND && s_d.fsm != ST_SEND && !s_d.tx.valid && s_q.hold.valid) begin
      s_d.tx = s_q.hold;
      s_d.hold.valid = 1'b0;
    end
    // ASCII byte taken into the hold register
    if (ascii_valid && s_q.ascii_ready) begin
      s_d.hold.valid = 1'b1;
      s_d.hold.data = ascii_data;
    end
    s_d.ascii_ready = !s_d.hold.valid;
  end

  // Register the whole state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign tx_valid = s_q.tx.valid;
  assign tx_data = s_q.tx.data;
  assign ascii_ready = s_q.ascii_ready;
  assign binary_busy = s_q.fsm[2];

endmodule // metering_message_framer

`default_nettype wire

// ==== test/host_sink.sv ====
// Partner: serial link host that takes the response stream, promptly or stalling
`timescale 1ns/1ps
`default_nettype none
module host_sink (
  input wire logic clk_sys,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic slow,
  output logic tx_ready
);
  logic [7:0] got[$];
  initial tx_ready = 1'b0;
  // Collect every byte taken
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // Ready every cycle, or every other cycle while stalling
  always @(negedge clk_sys) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
endmodule // host_sink
`default_nettype wire

// ==== test/metering_framer_properties.sv ====
// Checker: port-level timing properties of the metering message framer
`timescale 1ns/1ps
`default_nettype none
module framer_checker
  import metering_framer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic ascii_valid,
  input wire logic ascii_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic binary_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed before taken");
  property p_answer;
    !binary_busy && rx_valid && rx_data == CODE_LEAD ##1 rx_valid && rx_data == CODE_DEF |=> binary_busy;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_first;
    $rose(binary_busy) && !tx_valid |=> tx_valid && tx_data == CODE_LEAD;
  endproperty
  a_first: assert property (p_first) else $error("block does not open with lead byte");
  property p_cause;
    $rose(binary_busy) |-> $past(rx_valid && (rx_data == CODE_DEF || rx_data == CODE_CFG || rx_data == CODE_DATA));
  endproperty
  a_cause: assert property (p_cause) else $error("block opened without request");
  property p_lone;
    !binary_busy && rx_valid && rx_data == CODE_LEAD |=> !binary_busy;
  endproperty
  a_lone: assert property (p_lone) else $error("block opened on lead byte alone");
  property p_bound;
    $rose(binary_busy) |-> binary_busy[*8] ##[32:1000] !binary_busy;
  endproperty
  a_bound: assert property (p_bound) else $error("block length out of bounds");
  property p_stream;
    binary_busy && tx_valid && tx_ready |=> tx_valid;
  endproperty
  a_stream: assert property (p_stream) else $error("gap inside block");
  property p_ascii_take;
    ascii_valid && ascii_ready |=> !ascii_ready;
  endproperty
  a_ascii_take: assert property (p_ascii_take) else $error("hold not closed after take");
  property p_release;
    $fell(rst) |-> !tx_valid && !binary_busy && !ascii_ready ##1 ascii_ready;
  endproperty
  a_release: assert property (p_release) else $error("wrong state after reset");
endmodule // framer_checker

bind metering_message_framer framer_checker chk_i (.clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid),
  .rx_data(rx_data), .ascii_valid(ascii_valid), .ascii_ready(ascii_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .binary_busy(binary_busy));
`default_nettype wire

// ==== test/testbench.sv ====
// Testbench: request, stall, variant and pre-emption scenarios for the metering message framer
`timescale 1ns/1ps
`default_nettype none
module testbench
  import metering_framer_pkg::*;
;
  localparam logic [407:0] DEFB = {96'hA5C0_3404_0303_A5C1_A5D1_A5C2, 96'hA5D2_A5C3_A5D3_0004_A5C1_0000,
    96'h0000_0004_A5C2_0000_0000_0004, 96'hA5C3_0000_0000_0100_0101_0005, 24'h0006_00};
  localparam logic [127:0] CFGH = 128'hA5C1_8401_0000_0A02_3C01_0004_0054_005C;
  localparam logic [479:0] NAMES = {240'h4941_0000_0000_4942_0000_0000_4943_0000_0000_494E_0000_0000_5641_0000_0000,
    240'h5642_0000_0000_5643_0000_0000_5653_0000_0000_4652_4551_0000_5642_4154_0000};
  localparam logic [119:0] CALC = 120'h0000_FFFF_FFFF_FFFF_0001_0204_0506_00;
  logic clk_sys = 1'b0, rst = 1'b1, rx_valid = 1'b0, ascii_valid = 1'b0, ext = 1'b0, slow = 1'b0;
  logic [7:0] rx_data = 8'h00, ascii_data = 8'h00;
  logic tx_valid, tx_ready, ascii_ready, binary_busy;
  logic [7:0] tx_data;
  meter_snap_t snap = '0;
  logic [7:0] exp[$];
  int n_fail = 0, checks = 0, cyc = 0;
  metering_message_framer uut (.clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .ascii_valid(ascii_valid), .ascii_data(ascii_data), .ascii_ready(ascii_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .meter_snap(snap), .ext_variant(ext), .binary_busy(binary_busy));
  host_sink host (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_data(tx_data), .slow(slow), .tx_ready(tx_ready));
  // Clock and hang limit
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request bytes back to back, optionally with a doubled lead byte
  task req(input logic [7:0] c, input logic dup);
    rx_valid = 1'b1;
    rx_data = CODE_LEAD;
    if (dup) @(negedge clk_sys);
    @(negedge clk_sys);
    rx_data = c;
    @(negedge clk_sys);
    rx_valid = 1'b0;
  endtask
  // ASCII bytes offered at the falling edge, ready judged where it has settled
  task asend(input int n);
    for (int i = 0; i < n; i++) begin
      ascii_valid = 1'b1;
      ascii_data = 8'h30 + 8'(i);
      while (ascii_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    if (n > 0) ascii_valid = 1'b0;
  endtask
  // Expected block worked out from the field layout
  task mk(input logic [7:0] c);
    logic [7:0] s;
    exp = {};
    if (c == CODE_DEF) for (int i = 0; i < 51; i++) exp.push_back(DEFB[407-8*i -: 8]);
    if (c == CODE_CFG) begin
      for (int i = 0; i < 16; i++) exp.push_back(i == 8 ? (ext ? 8'h3D : 8'h3C) : CFGH[127-8*i -: 8]);
      for (int i = 0; i < 10; i++) begin
        for (int j = 0; j < 6; j++) exp.push_back(NAMES[479-48*i-8*j -: 8]);
        exp = {exp, 8'h01, 8'hFF, 8'h00, 8'h00};
      end
      for (int i = 0; i < 15; i++) exp.push_back(CALC[119-8*i -: 8]);
    end
    if (c == CODE_DATA) begin
      exp = {8'hA5, 8'hD1, ext ? 8'h9C : 8'h9A};
      for (int i = 0; i < 149 + ext; i++) exp.push_back(snap[1199-8*i -: 8]);
      for (int i = 0; i <= ext; i++) exp.push_back(8'h00);
    end
    s = 8'h00;
    foreach (exp[i]) s += exp[i];
    exp.push_back(s);
  endtask
  // One request, optional ASCII traffic and a stray request while busy
  task run(input string nm, input logic [7:0] c, input int na, input logic dup, input logic junk);
    int k, j;
    mk(c);
    host.got = {};
    fork
      asend(na);
      begin
        repeat (4) @(negedge clk_sys);
        req(c, dup);
        repeat (10) @(negedge clk_sys);
        if (junk) req(CODE_CFG, 1'b0);
      end
    join
    for (k = 0; k < 3000 && host.got.size() < exp.size() + na; k++) @(negedge clk_sys);
    repeat (6) @(negedge clk_sys);
    chk({nm, " size"}, 16'(exp.size() + na), 16'(host.got.size()));
    chk({nm, " busy"}, 16'h0000, {15'h0000, binary_busy});
    for (k = 0; k < host.got.size() && host.got[k] !== 8'hA5; k++) j = 0;
    j = 0;
    foreach (host.got[i]) begin
      if (i >= k && i < k + exp.size()) chk(nm, exp[i-k], host.got[i]);
      else begin
        chk({nm, " ascii"}, 16'h0030 + 16'(j), host.got[i]);
        j++;
      end
    end
  endtask
  task t_refuse;
    host.got = {};
    req(8'hC2, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk("dropped code", 16'h0000, 16'(host.got.size()));
  endtask
  task t_def_stall;
    slow = 1'b1;
    run("def stall", CODE_DEF, 0, 1'b1, 1'b0);
    slow = 1'b0;
  endtask
  task t_cfg_variants;
    run("cfg std", CODE_CFG, 0, 1'b0, 1'b0);
    ext = 1'b1;
    slow = 1'b1;
    run("cfg ext", CODE_CFG, 0, 1'b0, 1'b0);
    slow = 1'b0;
  endtask
  task t_data_variants;
    run("data ext", CODE_DATA, 0, 1'b0, 1'b1);
    ext = 1'b0;
    run("data std", CODE_DATA, 0, 1'b0, 1'b1);
  endtask
  task t_preempt;
    run("preempt", CODE_DEF, 5, 1'b0, 1'b0);
  endtask
  // Main sequence
  initial begin
    for (int i = 0; i < 150; i++) snap[1199-8*i -: 8] = 8'(i * 7 + 3);
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    t_refuse;
    t_def_stall;
    t_cfg_variants;
    t_data_variants;
    t_preempt;
    test_done;
  end
endmodule // testbench
`default_nettype wire
